// ===== design/flash_params.svh
// Constants for the serial flash configuration, protection and read handler.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

`define CFG_DUMMY_LEN_POS   6
`define CFG_ORIGIN_POS      3
`define CFG_RESET           8'h00
`define ST_LOCK_POS         7
`define ST_QUAD_POS         6
`define ST_GUARD_HI         5
`define ST_GUARD_LO         2
`define ST_LATCH_POS        1
`define ST_BUSY_POS         0
`define ST_RESET            8'h00

`define OP_WRITE_UNLOCK     8'h06
`define OP_WRITE_REGS       8'h01
`define OP_READ_STATUS      8'h05
`define OP_READ_CONFIG      8'h15
`define OP_READ_PLAIN       8'h03
`define OP_READ_DUMMY       8'h0b

`define DUAL_DUMMY_SHORT    4'h4
`define DUAL_DUMMY_LONG     4'h8
`define QUAD_DUMMY_SHORT    4'h6
`define QUAD_DUMMY_LONG     4'ha

`define ADDR_BITS_LAST      5'h17
`define DUMMY_BITS_LAST     5'h07
`define WR_BITS_SHORT       5'h08
`define WR_BITS_LONG        5'h10
`define GUARD_BLOCK_SHIFT   16

`define CLK_PERIOD_NS       5
`define WREG_TIME_NS        10000
`define WREG_CYCLES         (`WREG_TIME_NS / `CLK_PERIOD_NS)

`define FIFO_DEPTH          16

`endif

// ===== design/flash_pkg.sv
// Types shared by the serial flash handler.
package flash_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA_OUT,
      ST_WRITE_IN,
      ST_IGNORE
   } frame_state_t;

   typedef enum logic [1:0] {
      SRC_CONFIG,
      SRC_STATUS,
      SRC_ARRAY
   } out_src_t;

endpackage

// ===== design/byte_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_comb begin
      push  = in_valid & in_ready;
      pop   = out_valid & out_ready;
      wr_d  = wr_q + AW'(push);
      rd_d  = rd_q + AW'(pop);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      // Flushing drops everything; a write in the same cycle is lost too.
      if (flush) begin
         wr_d  = '0;
         rd_d  = '0;
         cnt_d = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule

// ===== design/flash_cfg_read.sv
// Serial flash command handler: configuration, register write, protection and reads.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_cfg_read #(
   parameter int WREG_CYCLES = `WREG_CYCLES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Serial pins
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        si,
   input  wire logic        write_guard_pin_n,
   output logic             so,
   output logic             so_oe,
   // Array read port
   output logic             mem_req_valid,
   input  wire logic        mem_req_ready,
   output logic [23:0]      mem_addr,
   input  wire logic        mem_rsp_valid,
   output logic             mem_rsp_ready,
   input  wire logic [7:0]  mem_rsp_data,
   // Program and erase engine
   input  wire logic        pe_busy,
   input  wire logic        pe_done,
   input  wire logic [23:0] pe_addr,
   output logic             pe_addr_guarded,
   // Mode outputs
   output logic             hard_guard_mode,
   output logic             quad_enable,
   output logic [3:0]       dual_dummy_cycles,
   output logic [3:0]       quad_dummy_cycles
);
   // Pin synchronisers; stage 0 feeds only stage 1.
   logic [2:0] sclk_s, cs_s;
   logic [1:0] si_s, wp_s;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         si_s   <= 2'h0;
         wp_s   <= 2'h3;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s   <= {cs_s[1:0], cs_n};
         si_s   <= {si_s[0], si};
         wp_s   <= {wp_s[0], write_guard_pin_n};
      end
   end

   logic sck_rise, sck_fall, frame_on, frame_end, si_b;
   assign sck_rise  = sclk_s[1] & ~sclk_s[2];
   assign sck_fall  = ~sclk_s[1] & sclk_s[2];
   assign frame_on  = ~cs_s[1];
   assign frame_end = cs_s[1] & ~cs_s[2];
   assign si_b      = si_s[1];

   flash_pkg::frame_state_t state_q, state_d;
   flash_pkg::out_src_t     src_q, src_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [23:0] in_sh_q, in_sh_d;
   logic [7:0]  out_sh_q, out_sh_d;
   logic [2:0]  bit_q, bit_d;
   logic        so_q, so_d, fast_q, fast_d;
   logic [23:0] fetch_q, fetch_d;
   logic        fetch_on_q, fetch_on_d, pend_q, pend_d, stale_q, stale_d;
   logic        lock_q, lock_d, quad_q, quad_d, wel_q, wel_d, wip_q, wip_d;
   logic [3:0]  guard_q, guard_d;
   logic        dlen_q, dlen_d, origin_q, origin_d;
   logic [7:0]  new_st_q, new_st_d, new_cfg_q, new_cfg_d;
   logic        new_has_cfg_q, new_has_cfg_d;
   logic [15:0] wtim_q, wtim_d;

   logic        busy, fifo_in_ready, fifo_valid, fifo_pop, fifo_push;
   logic [7:0]  fifo_data, status_byte, config_byte, out_byte, opcode;

   assign busy            = wip_q | pe_busy;
   assign hard_guard_mode = lock_q & ~wp_s[1];
   assign quad_enable     = quad_q;
   assign status_byte     = {lock_q, quad_q, guard_q, wel_q, busy};
   assign config_byte     = {1'b0, dlen_q, 2'b00, origin_q, 3'b000};
   assign dual_dummy_cycles = dlen_q ? `DUAL_DUMMY_LONG : `DUAL_DUMMY_SHORT;
   assign quad_dummy_cycles = dlen_q ? `QUAD_DUMMY_LONG : `QUAD_DUMMY_SHORT;
   assign so              = so_q;
   assign so_oe           = frame_on & (state_q == flash_pkg::ST_DATA_OUT);
   assign mem_addr        = fetch_q;
   // Only one fetch is in flight, so a non-full FIFO always has room for it.
   assign mem_req_valid   = fetch_on_q & frame_on & ~pend_q & ~stale_q & fifo_in_ready;
   assign mem_rsp_ready   = stale_q | fifo_in_ready;
   assign fifo_push       = mem_rsp_valid & ~stale_q;
   assign opcode          = {in_sh_q[6:0], si_b};

   // Guarded region grows in 64 KiB blocks from the top or from the bottom.
   logic [8:0] blk_cnt;
   logic [7:0] blk_idx;
   always_comb begin
      blk_idx = pe_addr[23:`GUARD_BLOCK_SHIFT];
      if (guard_q == 4'h0) begin
         blk_cnt = 9'h000;
      end else if (guard_q > 4'h9) begin
         blk_cnt = 9'h100;
      end else begin
         blk_cnt = 9'h001 << (guard_q - 4'h1);
      end
      if (origin_q) begin
         pe_addr_guarded = ({1'b0, blk_idx} < blk_cnt);
      end else begin
         pe_addr_guarded = ({1'b0, blk_idx} >= (9'h100 - blk_cnt));
      end
   end

   always_comb begin
      state_d = state_q;
      src_d   = src_q;
      cnt_d   = cnt_q;
      in_sh_d = in_sh_q;
      out_sh_d = out_sh_q;
      bit_d   = bit_q;
      so_d    = so_q;
      fast_d  = fast_q;
      fetch_d = fetch_q;
      fetch_on_d = fetch_on_q;
      pend_d  = pend_q;
      stale_d = stale_q;
      lock_d  = lock_q;
      quad_d  = quad_q;
      wel_d   = wel_q;
      wip_d   = wip_q;
      guard_d = guard_q;
      dlen_d  = dlen_q;
      origin_d = origin_q;
      new_st_d = new_st_q;
      new_cfg_d = new_cfg_q;
      new_has_cfg_d = new_has_cfg_q;
      wtim_d  = wtim_q;
      fifo_pop = 1'b0;
      out_byte = 8'hff;

      if (mem_req_valid & mem_req_ready) begin
         pend_d  = 1'b1;
         fetch_d = fetch_q + 24'h000001;
      end
      if (mem_rsp_valid & mem_rsp_ready) begin
         pend_d  = 1'b0;
         stale_d = 1'b0;
      end

      // Self-timed register write; new values land only at completion.
      if (wip_q) begin
         wtim_d = wtim_q - 16'h0001;
         if (wtim_q == 16'h0001) begin
            wip_d   = 1'b0;
            wel_d   = 1'b0;
            lock_d  = new_st_q[`ST_LOCK_POS];
            quad_d  = new_st_q[`ST_QUAD_POS];
            guard_d = new_st_q[`ST_GUARD_HI:`ST_GUARD_LO];
            if (new_has_cfg_q) begin
               dlen_d   = new_cfg_q[`CFG_DUMMY_LEN_POS];
               origin_d = origin_q | new_cfg_q[`CFG_ORIGIN_POS];
            end
         end
      end
      if (pe_done) begin
         wel_d = 1'b0;
      end

      if (!frame_on) begin
         state_d    = flash_pkg::ST_IDLE;
         fetch_on_d = 1'b0;
         if (pend_q & ~(mem_rsp_valid & mem_rsp_ready)) begin
            stale_d = 1'b1;
         end
         // Any bit count other than 8 or 16 drops the command.
         if (frame_end && state_q == flash_pkg::ST_WRITE_IN && wel_q && !busy
             && !hard_guard_mode
             && (cnt_q == `WR_BITS_SHORT || cnt_q == `WR_BITS_LONG)) begin
            wip_d  = 1'b1;
            wtim_d = WREG_CYCLES[15:0];
            new_has_cfg_d = (cnt_q == `WR_BITS_LONG);
            new_st_d  = (cnt_q == `WR_BITS_LONG) ? in_sh_q[15:8] : in_sh_q[7:0];
            new_cfg_d = in_sh_q[7:0];
         end
      end else begin
         case (state_q)
            flash_pkg::ST_IDLE: begin
               state_d = flash_pkg::ST_OPCODE;
               cnt_d   = 5'h00;
            end
            flash_pkg::ST_OPCODE: begin
               if (sck_rise) begin
                  in_sh_d = {in_sh_q[22:0], si_b};
                  cnt_d   = cnt_q + 5'h01;
                  if (cnt_q == 5'h07) begin
                     cnt_d   = 5'h00;
                     bit_d   = 3'h0;
                     state_d = flash_pkg::ST_IGNORE;
                     fast_d  = (opcode == `OP_READ_DUMMY);
                     case (opcode)
                        `OP_WRITE_UNLOCK: begin
                           if (!busy) begin
                              wel_d = 1'b1;
                           end
                        end
                        `OP_WRITE_REGS: begin
                           if (!busy) begin
                              state_d = flash_pkg::ST_WRITE_IN;
                           end
                        end
                        `OP_READ_CONFIG: begin
                           state_d = flash_pkg::ST_DATA_OUT;
                           src_d   = flash_pkg::SRC_CONFIG;
                        end
                        `OP_READ_STATUS: begin
                           state_d = flash_pkg::ST_DATA_OUT;
                           src_d   = flash_pkg::SRC_STATUS;
                        end
                        `OP_READ_PLAIN, `OP_READ_DUMMY: begin
                           if (!busy) begin
                              state_d = flash_pkg::ST_ADDR;
                              src_d   = flash_pkg::SRC_ARRAY;
                           end
                        end
                        default: state_d = flash_pkg::ST_IGNORE;
                     endcase
                  end
               end
            end
            flash_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  in_sh_d = {in_sh_q[22:0], si_b};
                  cnt_d   = cnt_q + 5'h01;
                  if (cnt_q == `ADDR_BITS_LAST) begin
                     cnt_d      = 5'h00;
                     fetch_d    = {in_sh_q[22:0], si_b};
                     fetch_on_d = 1'b1;
                     state_d    = fast_q ? flash_pkg::ST_DUMMY
                                         : flash_pkg::ST_DATA_OUT;
                  end
               end
            end
            flash_pkg::ST_DUMMY: begin
               if (sck_rise) begin
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == `DUMMY_BITS_LAST) begin
                     state_d = flash_pkg::ST_DATA_OUT;
                  end
               end
            end
            flash_pkg::ST_DATA_OUT: begin
               if (sck_fall) begin
                  bit_d = bit_q + 3'h1;
                  if (bit_q == 3'h0) begin
                     case (src_q)
                        flash_pkg::SRC_CONFIG: out_byte = config_byte;
                        flash_pkg::SRC_STATUS: out_byte = status_byte;
                        default: begin
                           out_byte = fifo_valid ? fifo_data : 8'hff;
                           fifo_pop = fifo_valid;
                        end
                     endcase
                     so_d     = out_byte[7];
                     out_sh_d = {out_byte[6:0], 1'b0};
                  end else begin
                     so_d     = out_sh_q[7];
                     out_sh_d = {out_sh_q[6:0], 1'b0};
                  end
               end
            end
            flash_pkg::ST_WRITE_IN: begin
               if (sck_rise) begin
                  in_sh_d = {in_sh_q[22:0], si_b};
                  if (cnt_q != 5'h1f) begin
                     cnt_d = cnt_q + 5'h01;
                  end
               end
            end
            default: state_d = flash_pkg::ST_IGNORE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= flash_pkg::ST_IDLE;
         src_q   <= flash_pkg::SRC_CONFIG;
         cnt_q   <= 5'h00;
         in_sh_q <= 24'h000000;
         out_sh_q <= 8'h00;
         bit_q   <= 3'h0;
         so_q    <= 1'b0;
         fast_q  <= 1'b0;
         fetch_q <= 24'h000000;
         fetch_on_q <= 1'b0;
         pend_q  <= 1'b0;
         stale_q <= 1'b0;
         lock_q  <= 1'(`ST_RESET >> `ST_LOCK_POS);
         quad_q  <= 1'b0;
         wel_q   <= 1'b0;
         wip_q   <= 1'b0;
         guard_q <= 4'h0;
         dlen_q  <= 1'b0;
         origin_q <= 1'b0;
         new_st_q <= `ST_RESET;
         new_cfg_q <= `CFG_RESET;
         new_has_cfg_q <= 1'b0;
         wtim_q  <= 16'h0000;
      end else begin
         state_q <= state_d;
         src_q   <= src_d;
         cnt_q   <= cnt_d;
         in_sh_q <= in_sh_d;
         out_sh_q <= out_sh_d;
         bit_q   <= bit_d;
         so_q    <= so_d;
         fast_q  <= fast_d;
         fetch_q <= fetch_d;
         fetch_on_q <= fetch_on_d;
         pend_q  <= pend_d;
         stale_q <= stale_d;
         lock_q  <= lock_d;
         quad_q  <= quad_d;
         wel_q   <= wel_d;
         wip_q   <= wip_d;
         guard_q <= guard_d;
         dlen_q  <= dlen_d;
         origin_q <= origin_d;
         new_st_q <= new_st_d;
         new_cfg_q <= new_cfg_d;
         new_has_cfg_q <= new_has_cfg_d;
         wtim_q  <= wtim_d;
      end
   end

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst | ~frame_on),
      .flush     (~fetch_on_q),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_rsp_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

endmodule

// ===== bench/flash_cfg_read_assertions.sv
// Port-level property checker for the serial flash command handler.
`timescale 1ns/1ps
module flash_cfg_read_assertions #(
   parameter int WREG_CYCLES = 20
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        cs_n,
   input  wire logic        write_guard_pin_n,
   input  wire logic        so_oe,
   input  wire logic        mem_req_valid,
   input  wire logic        mem_req_ready,
   input  wire logic [23:0] mem_addr,
   input  wire logic        hard_guard_mode,
   input  wire logic [3:0]  dual_dummy_cycles,
   input  wire logic [3:0]  quad_dummy_cycles
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence req_wait;
      mem_req_valid && !mem_req_ready;
   endsequence
   sequence deselected;
      cs_n [*6];
   endsequence
   chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !so_oe && !hard_guard_mode)
      else $error("outputs not quiet after reset");
   chk_oe_release: assert property (deselected |-> !so_oe)
      else $error("output driven while deselected");
   chk_oe_frame: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 4))
      else $error("output enabled outside a frame");
   chk_dummy_dual: assert property (dual_dummy_cycles == 4'h4 || dual_dummy_cycles == 4'h8)
      else $error("dual dummy count out of range");
   chk_dummy_pair: assert property ((quad_dummy_cycles == 4'h6 || quad_dummy_cycles == 4'ha)
      && ((dual_dummy_cycles == 4'h8) == (quad_dummy_cycles == 4'ha)))
      else $error("dummy counts disagree");
   chk_guard_exit: assert property (write_guard_pin_n [*4] |-> !hard_guard_mode)
      else $error("hard guard held with pin high");
   chk_guard_entry: assert property ($rose(hard_guard_mode) |-> !$past(write_guard_pin_n, 2))
      else $error("hard guard entered with pin high");
   chk_fetch_hold: assert property (req_wait |=> mem_req_valid && $stable(mem_addr))
      else $error("fetch request dropped or moved");
endmodule

bind flash_cfg_read flash_cfg_read_assertions #(.WREG_CYCLES(WREG_CYCLES)) chk (
   .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .write_guard_pin_n(write_guard_pin_n),
   .so_oe(so_oe), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
   .mem_addr(mem_addr), .hard_guard_mode(hard_guard_mode),
   .dual_dummy_cycles(dual_dummy_cycles), .quad_dummy_cycles(quad_dummy_cycles));

// ===== bench/spi_host_model.sv
// Behavioural host controller that frames commands on the serial pins.
`timescale 1ns/1ps
module spi_host_model (
   // Serial pins
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   task automatic shift(input logic b);
      si = b;
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
   endtask
   // The clock stands still between frames; the data line toggles so stale bits never pass.
   task automatic frame(input logic [7:0] op, input logic [31:0] tx, input int ntx,
                        input int nrx, output logic [31:0] rx);
      int i;
      rx = '0;
      cs_n = 1'b0;
      #32;
      for (i = 7; i >= 0; i--) shift(op[i]);
      for (i = ntx - 1; i >= 0; i--) shift(tx[i]);
      for (i = 0; i < nrx; i++) begin
         si = ~si;
         #32 rx = {rx[30:0], so};
         sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      si = ~si;
      #64;
   endtask
endmodule

// ===== bench/flash_cfg_read_tb.sv
// Self-checking bench for the serial flash command handler.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_cfg_read_tb;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cs_n, sclk, si, so, so_oe, req_v, rsp_rdy, guarded, hard_guard;
   logic        guard_n = 1'b1, req_rdy = 1'b0, rsp_v = 1'b0, pe_busy = 1'b0, pe_done = 1'b0;
   logic [23:0] mem_addr, pe_addr = 24'h000000;
   logic [7:0]  rsp_data = 8'h00;
   logic [3:0]  dual_n, quad_n;
   logic [31:0] rxv;
   logic        oe_seen = 1'b0, quad_en;
   int          fails = 0, comparisons = 0, cycles = 0;

   always #2.5 core_clk = ~core_clk;

   flash_cfg_read #(.WREG_CYCLES(600)) dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
      .sclk(sclk), .si(si), .write_guard_pin_n(guard_n), .so(so), .so_oe(so_oe),
      .mem_req_valid(req_v), .mem_req_ready(req_rdy), .mem_addr(mem_addr),
      .mem_rsp_valid(rsp_v), .mem_rsp_ready(rsp_rdy), .mem_rsp_data(rsp_data),
      .pe_busy(pe_busy), .pe_done(pe_done), .pe_addr(pe_addr), .pe_addr_guarded(guarded),
      .hard_guard_mode(hard_guard), .quad_enable(quad_en), .dual_dummy_cycles(dual_n),
      .quad_dummy_cycles(quad_n));
   spi_host_model host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'h5a;
   endfunction

   // Array model: the request waits one cycle for ready so the hold logic is exercised.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      req_rdy <= req_v && !req_rdy;
      if (so_oe) oe_seen <= 1'b1;
      if (req_v && req_rdy) begin
         rsp_v <= 1'b1;
         rsp_data <= pat(mem_addr);
      end else if (rsp_v && rsp_rdy) rsp_v <= 1'b0;
      if (cycles == 40000) begin
         fails = fails + 1;
         close_out();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] tx, input int ntx, input int nrx);
      host.frame(op, tx, ntx, nrx, rxv);
   endtask
   task automatic st_is(input logic [7:0] exp, input logic [7:0] mask);
      cmd(`OP_READ_STATUS, 32'h0, 0, 8);
      check(rxv & mask, exp, "status");
   endtask
   task automatic cf_is(input logic [7:0] exp);
      cmd(`OP_READ_CONFIG, 32'h0, 0, 8);
      check(rxv, exp, "config");
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 40; n++) begin
         cmd(`OP_READ_STATUS, 32'h0, 0, 8);
         if (rxv[0] === 1'b0) break;
      end
   endtask
   task automatic wregs(input logic [15:0] d, input int n);
      cmd(`OP_WRITE_UNLOCK, 32'h0, 0, 0);
      cmd(`OP_WRITE_REGS, {16'h0, d}, n, 0);
   endtask
   task automatic guard_is(input logic e);
      for (int n = 0; n < 10 && hard_guard !== e; n++) @(posedge core_clk);
      check(hard_guard, e, "hard guard");
   endtask
   task automatic guarded_at(input logic [23:0] a, input logic e);
      @(posedge core_clk) pe_addr <= a;
      @(posedge core_clk);
      #1 check(guarded, e, "guarded");
   endtask

   task automatic t_reset();
      cf_is(8'h00);
      st_is(8'h00, 8'hff);
      check({dual_n, quad_n}, 8'h46, "dummy");
      guarded_at(24'hff0000, 1'b0);
      cmd(`OP_WRITE_REGS, 32'h84, 8, 0);
      st_is(8'h00, 8'hff);
      $display("test reset done");
   endtask
   task automatic t_write();
      cmd(`OP_WRITE_UNLOCK, 32'h0, 0, 0);
      st_is(8'h02, 8'hff);
      cmd(`OP_WRITE_REGS, 32'h8748, 16, 0);
      st_is(8'h03, 8'h03);
      cf_is(8'h00);
      wait_idle();
      st_is(8'h84, 8'hff);
      cf_is(8'h48);
      check({dual_n, quad_n}, 8'h8a, "dummy");
      guarded_at(24'h000010, 1'b1);
      guarded_at(24'hff0010, 1'b0);
      $display("test write done");
   endtask
   task automatic t_guard();
      @(posedge core_clk) guard_n <= 1'b0;
      guard_is(1'b1);
      wregs(16'h0000, 8);
      wait_idle();
      st_is(8'h84, 8'hfc);
      @(posedge core_clk) guard_n <= 1'b1;
      guard_is(1'b0);
      wregs(16'h0400, 16);
      wait_idle();
      st_is(8'h04, 8'hff);
      cf_is(8'h08);
      wregs(16'h0fc, 12);
      wait_idle();
      st_is(8'h04, 8'hfc);
      // A status-only write must leave the configuration byte alone.
      wregs(16'h0040, 8);
      wait_idle();
      st_is(8'h40, 8'hff);
      cf_is(8'h08);
      check(quad_en, 1'b1, "quad enable");
      $display("test guard done");
   endtask
   task automatic t_engine();
      cmd(`OP_WRITE_UNLOCK, 32'h0, 0, 0);
      @(posedge core_clk) pe_busy <= 1'b1;
      oe_seen <= 1'b0;
      cmd(`OP_READ_DUMMY, 32'h00010000, 32, 8);
      check(oe_seen, 1'b0, "fast read refused");
      st_is(8'h03, 8'h03);
      @(posedge core_clk) pe_busy <= 1'b0;
      @(posedge core_clk) pe_done <= 1'b1;
      @(posedge core_clk) pe_done <= 1'b0;
      st_is(8'h00, 8'h03);
      $display("test engine done");
   endtask
   task automatic t_reads();
      cmd(`OP_READ_PLAIN, 32'hfffffe, 24, 24);
      check(rxv[23:0], {pat(24'hfffffe), pat(24'hffffff), pat(24'h0)}, "plain");
      repeat (8) @(posedge core_clk);
      check(so_oe, 1'b0, "release");
      cmd(`OP_READ_DUMMY, 32'h00010000, 32, 16);
      check(rxv[15:0], {pat(24'h000100), pat(24'h000101)}, "fast");
      $display("test reads done");
   endtask
   task automatic t_fifo();
      // The read buffer runs full during the first byte, so order must survive back-pressure.
      cmd(`OP_READ_PLAIN, 32'h000030, 24, 32);
      check(rxv, {pat(24'h30), pat(24'h31), pat(24'h32), pat(24'h33)}, "stream");
      // Bytes left over from the last frame must never leak into the next one.
      cmd(`OP_READ_DUMMY, 32'h00200000, 32, 8);
      check(rxv[7:0], pat(24'h002000), "flushed");
      $display("test fifo done");
   endtask

   task automatic close_out();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_write();
      t_guard();
      t_engine();
      t_reads();
      t_fifo();
      close_out();
   end
endmodule
